// ==== rtl/mps_pkg.sv ====
// Shared constants and carrier types for the multipurpose pin sharing block
package mps_pkg;

   // ------------------------------------------------------------------
   // Pin indices on the shared pad vector
   // ------------------------------------------------------------------
   localparam int NPIN   = 22;
   localparam int P_MOSI = 0;
   localparam int P_TX0  = 1;
   localparam int P_RX0  = 2;
   localparam int P_T2A  = 3;
   localparam int P_T2B  = 4;
   localparam int P_SDA  = 5;
   localparam int P_SCL  = 6;
   localparam int P_CF1  = 7;
   localparam int P_CF2  = 8;
   localparam int P_TMS  = 9;
   localparam int P_TCK  = 10;
   localparam int P_TDI  = 11;
   localparam int P_TDO  = 12;
   localparam int P_TBB  = 13;
   localparam int P_TBA  = 14;
   localparam int P_RX1  = 15;
   localparam int P_TX1  = 16;
   localparam int P_RST  = 17;
   localparam int P_MD0P = 18;
   localparam int P_SSEL = 19;
   localparam int P_SCLK = 20;
   localparam int P_MISO = 21;

   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_OWNER     = 8'h04;
   localparam logic [7:0]  REG_CONFLICT  = 8'h08;
   localparam int          CTRL_RST_DIS  = 0;
   localparam int          CTRL_CLK_OUT  = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic md0_en;
      logic md1_en;
      logic md2_en;
      logic spi_en;
      logic i2c_en;
      logic jtag_en;
      logic sqw_en;
      logic pulse1_en;
      logic pulse2_en;
      logic ser0_tx_busy;
      logic ser1_tx_busy;
      logic ser0_rx_en;
      logic ser1_rx_en;
      logic tmr2_out_en;
      logic tmrb_a_out_en;
      logic tmrb_b_out_en;
   } mps_en_t;

   typedef struct packed {
      logic spi_mosi;
      logic spi_sclk;
      logic spi_ssel;
      logic sda_low;
      logic scl_low;
      logic serial0_tx;
      logic serial1_tx;
      logic pulse_out_1;
      logic pulse_out_2;
      logic tdo;
      logic tdo_oe;
      logic square_wave_out;
      logic timer2_primary_pin;
      logic timer2_secondary_pin;
      logic timerb_pin_a;
      logic timerb_pin_b;
      logic sysclk_level;
   } mps_drv_t;

endpackage

// ==== rtl/mps_pin_mux.sv ====
// Multipurpose pin sharing with an AXI4-Lite control slave
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mps_pin_mux
   import mps_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // Peripheral enables and drive values
   input  wire mps_en_t           en_in,
   input  wire mps_drv_t          drv_in,
   // Port function
   input  wire logic [NPIN-1:0]   port_out_in,
   input  wire logic [NPIN-1:0]   port_oe_in,
   output logic      [NPIN-1:0]   port_in_out,
   // Pads
   input  wire logic [NPIN-1:0]   pad_in,
   output logic      [NPIN-1:0]   pad_out,
   output logic      [NPIN-1:0]   pad_oe_out,
   // Inputs towards peripherals
   output logic      [NPIN-1:0]   pin_in_out,
   output logic                   serial0_rx_out,
   output logic                   serial1_rx_out,
   output logic                   device_reset_out,
   output logic                   spi_usable_out,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must be 4 to 8");
   end

   // ------------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------------
   logic [1:0]        ctrl;
   logic [NPIN-1:0]   own;
   logic [NPIN-1:0]   conflict;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic              w_strb0;
   logic [1:0]        next_ctrl;
   logic [ADDR_W-1:0] next_aw_addr;
   logic [31:0]       next_w_data;
   logic              next_w_strb0;
   logic              next_awready;
   logic              next_wready;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_arready;
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;

   always_comb begin
      next_ctrl    = ctrl;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb0 = w_strb0;
      next_awready = s_axi_awready;
      next_wready  = s_axi_wready;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data  = s_axi_wdata;
         next_w_strb0 = s_axi_wstrb[0];
         next_wready  = 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
         next_bvalid = 1'b1;
         next_bresp  = RESP_OKAY;
         if (aw_addr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) begin
            if (w_strb0) begin
               next_ctrl = w_data[1:0];
            end
         end else if (aw_addr[ADDR_W-1:2] == REG_OWNER[ADDR_W-1:2]) begin
            next_bresp = RESP_OKAY;
         end else if (aw_addr[ADDR_W-1:2] == REG_CONFLICT[ADDR_W-1:2]) begin
            next_bresp = RESP_OKAY;
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid  = 1'b0;
         next_awready = 1'b1;
         next_wready  = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = RESP_OKAY;
         if (s_axi_araddr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) begin
            next_rdata = {30'h0, ctrl};
         end else if (s_axi_araddr[ADDR_W-1:2] == REG_OWNER[ADDR_W-1:2]) begin
            next_rdata = {10'h0, own};
         end else if (s_axi_araddr[ADDR_W-1:2] == REG_CONFLICT[ADDR_W-1:2]) begin
            next_rdata = {10'h0, conflict};
         end else begin
            next_rdata = 32'h0;
            next_rresp = RESP_SLVERR;
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl          <= CTRL_RESET;
         aw_addr       <= '0;
         w_data        <= 32'h0;
         w_strb0       <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         ctrl          <= next_ctrl;
         aw_addr       <= next_aw_addr;
         w_data        <= next_w_data;
         w_strb0       <= next_w_strb0;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ------------------------------------------------------------------
   // Pin ownership by fixed priority
   // ------------------------------------------------------------------
   logic [NPIN-1:0] p_own;
   logic [NPIN-1:0] p_val;
   logic [NPIN-1:0] p_oe;
   logic [NPIN-1:0] p_conf;
   logic [NPIN-1:0] next_pad_out;
   logic [NPIN-1:0] next_pad_oe;
   logic [NPIN-1:0] next_port_in;
   logic            clk_out_en;

   assign clk_out_en = ctrl[CTRL_CLK_OUT];

   always_comb begin
      p_own  = '0;
      p_val  = '0;
      p_oe   = '0;
      p_conf = '0;
      // Decoder inputs win over SPI; input-only owners drive nothing
      p_own[P_MOSI] = en_in.md2_en | en_in.spi_en;
      p_val[P_MOSI] = drv_in.spi_mosi;
      p_oe[P_MOSI]  = en_in.spi_en & ~en_in.md2_en;
      p_conf[P_MOSI] = en_in.md2_en & en_in.spi_en;
      p_own[P_TX0]  = en_in.ser0_tx_busy;
      p_val[P_TX0]  = drv_in.serial0_tx;
      p_oe[P_TX0]   = en_in.ser0_tx_busy;
      p_own[P_TX1]  = en_in.ser1_tx_busy;
      p_val[P_TX1]  = drv_in.serial1_tx;
      p_oe[P_TX1]   = en_in.ser1_tx_busy;
      p_own[P_T2A]  = en_in.md1_en | en_in.tmr2_out_en;
      p_val[P_T2A]  = drv_in.timer2_primary_pin;
      p_oe[P_T2A]   = en_in.tmr2_out_en & ~en_in.md1_en;
      p_conf[P_T2A] = en_in.md1_en & en_in.tmr2_out_en;
      p_own[P_T2B]  = en_in.md1_en | en_in.tmr2_out_en;
      p_val[P_T2B]  = drv_in.timer2_secondary_pin;
      p_oe[P_T2B]   = en_in.tmr2_out_en & ~en_in.md1_en;
      p_conf[P_T2B] = en_in.md1_en & en_in.tmr2_out_en;
      // Two-wire bus pins are open drain: drive low only
      p_own[P_SDA]  = en_in.i2c_en;
      p_oe[P_SDA]   = en_in.i2c_en & drv_in.sda_low;
      p_own[P_SCL]  = en_in.i2c_en;
      p_oe[P_SCL]   = en_in.i2c_en & drv_in.scl_low;
      p_own[P_CF1]  = en_in.pulse1_en;
      p_val[P_CF1]  = drv_in.pulse_out_1;
      p_oe[P_CF1]   = en_in.pulse1_en;
      p_own[P_CF2]  = en_in.pulse2_en;
      p_val[P_CF2]  = drv_in.pulse_out_2;
      p_oe[P_CF2]   = en_in.pulse2_en;
      p_own[P_TMS]  = en_in.jtag_en;
      p_own[P_TCK]  = en_in.jtag_en;
      p_own[P_TDI]  = en_in.jtag_en;
      p_own[P_TDO]  = en_in.jtag_en | en_in.sqw_en;
      p_val[P_TDO]  = en_in.jtag_en ? drv_in.tdo : drv_in.square_wave_out;
      p_oe[P_TDO]   = en_in.jtag_en ? drv_in.tdo_oe : en_in.sqw_en;
      p_conf[P_TDO] = en_in.jtag_en & en_in.sqw_en;
      p_own[P_TBB]  = en_in.tmrb_b_out_en;
      p_val[P_TBB]  = drv_in.timerb_pin_b;
      p_oe[P_TBB]   = en_in.tmrb_b_out_en;
      p_own[P_TBA]  = en_in.tmrb_a_out_en;
      p_val[P_TBA]  = drv_in.timerb_pin_a;
      p_oe[P_TBA]   = en_in.tmrb_a_out_en;
      p_own[P_MD0P] = en_in.md0_en;
      p_own[P_SSEL] = en_in.md0_en | en_in.spi_en;
      p_val[P_SSEL] = drv_in.spi_ssel;
      p_oe[P_SSEL]  = en_in.spi_en & ~en_in.md0_en;
      p_conf[P_SSEL] = en_in.md0_en & en_in.spi_en;
      p_own[P_SCLK] = clk_out_en | en_in.spi_en;
      p_val[P_SCLK] = clk_out_en ? drv_in.sysclk_level : drv_in.spi_sclk;
      p_oe[P_SCLK]  = 1'b1;
      p_conf[P_SCLK] = clk_out_en & en_in.spi_en;
      p_own[P_MISO] = en_in.md2_en | en_in.spi_en;
      p_conf[P_MISO] = en_in.md2_en & en_in.spi_en;
   end

   // One driver per pin: peripheral when owned, else the port
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      assign next_pad_out[i] = p_own[i] ? p_val[i] : port_out_in[i];
      assign next_pad_oe[i]  = p_own[i] ? p_oe[i]  : port_oe_in[i];
      assign next_port_in[i] = (i >= P_TMS && i <= P_TDO && en_in.jtag_en) ? 1'b0 : pad_in[i];
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pad_out          <= '0;
         pad_oe_out       <= '0;
         port_in_out      <= '0;
         pin_in_out       <= '0;
         own              <= '0;
         conflict         <= '0;
         serial0_rx_out   <= 1'b1;
         serial1_rx_out   <= 1'b1;
         device_reset_out <= 1'b0;
         spi_usable_out   <= 1'b0;
      end else begin
         pad_out          <= next_pad_out;
         pad_oe_out       <= next_pad_oe;
         port_in_out      <= next_port_in;
         pin_in_out       <= pad_in;
         own              <= p_own;
         conflict         <= p_conf;
         serial0_rx_out   <= en_in.ser0_rx_en ? pad_in[P_RX0] : 1'b1;
         serial1_rx_out   <= en_in.ser1_rx_en ? pad_in[P_RX1] : 1'b1;
         device_reset_out <= ~pad_in[P_RST] & ~ctrl[CTRL_RST_DIS];
         spi_usable_out   <= en_in.spi_en & ~clk_out_en & ~en_in.md0_en & ~en_in.md2_en;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_tx_drive_busy: assert property (@(posedge clk_in) disable iff (rst_in)
      en_in.ser0_tx_busy |=> pad_oe_out[P_TX0] && pad_out[P_TX0] == $past(drv_in.serial0_tx))
      else $error("serial transmit not on pin while busy");
   chk_tx_idle_port: assert property (@(posedge clk_in) disable iff (rst_in)
      !en_in.ser1_tx_busy |=> pad_oe_out[P_TX1] == $past(port_oe_in[P_TX1]))
      else $error("port lost transmit pin while idle");
   chk_rx_gated_off: assert property (@(posedge clk_in) disable iff (rst_in)
      !en_in.ser0_rx_en |=> serial0_rx_out)
      else $error("receive path active while disabled");
   chk_pulse_owns_pin: assert property (@(posedge clk_in) disable iff (rst_in)
      en_in.pulse1_en |=> pad_oe_out[P_CF1] && pad_out[P_CF1] == $past(drv_in.pulse_out_1))
      else $error("pulse output not driving its pin");
   chk_jtag_port_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
      en_in.jtag_en |=> port_in_out[P_TDO:P_TMS] == 4'h0 && pad_oe_out[P_TMS] == 1'b0)
      else $error("port still uses test pins");
   chk_sqw_blocked: assert property (@(posedge clk_in) disable iff (rst_in)
      en_in.jtag_en && en_in.sqw_en |=> pad_out[P_TDO] == $past(drv_in.tdo))
      else $error("square wave reached test data pin");
   chk_reset_pin_low: assert property (@(posedge clk_in) disable iff (rst_in)
      !pad_in[P_RST] && !ctrl[CTRL_RST_DIS] |=> device_reset_out)
      else $error("low reset pin did not reset");
   chk_reset_disabled: assert property (@(posedge clk_in) disable iff (rst_in)
      ctrl[CTRL_RST_DIS] |=> !device_reset_out)
      else $error("reset taken while pin reset disabled");
   chk_clk_out_pin: assert property (@(posedge clk_in) disable iff (rst_in)
      clk_out_en |=> pad_out[P_SCLK] == $past(drv_in.sysclk_level) && !spi_usable_out)
      else $error("clock output not on shared pin");
   chk_one_driver_mosi: assert property (@(posedge clk_in) disable iff (rst_in)
      en_in.md2_en && en_in.spi_en |=> !pad_oe_out[P_MOSI] && conflict[P_MOSI])
      else $error("two drivers on shared pin");

endmodule
`default_nettype wire

// ==== testbench/mps_board.sv ====
// Board model of the parts wired to the shared pads
`timescale 1ns/1ps
`default_nettype none
module mps_board
   import mps_pkg::*;
(
   // Pad side of the block
   input  wire logic [NPIN-1:0] pad_out_in,
   input  wire logic [NPIN-1:0] pad_oe_in,
   output logic      [NPIN-1:0] pad_level_out,
   // Outside sources
   input  wire logic [NPIN-1:0] ext_in,
   input  wire logic            button_in
);
   // -----------------------------------------------------------------
   // Pad levels
   // -----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         pad_level_out[i] = pad_oe_in[i] ? pad_out_in[i] : ext_in[i];
      end
      // Pull-ups on the open-drain bus lines
      if (!pad_oe_in[P_SDA])
         pad_level_out[P_SDA] = 1'b1;
      if (!pad_oe_in[P_SCL])
         pad_level_out[P_SCL] = 1'b1;
      // Pull-up and push button to ground on the reset pad
      if (!pad_oe_in[P_RST])
         pad_level_out[P_RST] = !button_in;
   end
endmodule
`default_nettype wire

// ==== testbench/mps_pin_mux_tb.sv ====
// Self-checking testbench of the pin sharing block
`timescale 1ns/1ps
`default_nettype none
module mps_pin_mux_tb
   import mps_pkg::*;
;
   logic            clk_in;
   logic            rst_in;
   mps_en_t         en;
   mps_drv_t        drv;
   logic [NPIN-1:0] port_out, port_oe, port_in, pad_in, pad_out, pad_oe, pin_in, ext;
   logic            rx0, rx1, dev_rst, spi_ok, button;
   logic [7:0]      awaddr, araddr;
   logic [31:0]     wdata, rdata, rd;
   logic [3:0]      wstrb;
   logic [1:0]      bresp, rresp, rs, ctrl_v;
   logic            awvalid, awready, wvalid, wready, bvalid, bready;
   logic            arvalid, arready, rvalid, rready;
   int              n_fail, checked;

   mps_pin_mux dut_u (.clk_in(clk_in), .rst_in(rst_in), .en_in(en), .drv_in(drv),
      .port_out_in(port_out), .port_oe_in(port_oe), .port_in_out(port_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_out(pad_oe), .pin_in_out(pin_in), .serial0_rx_out(rx0),
      .serial1_rx_out(rx1), .device_reset_out(dev_rst), .spi_usable_out(spi_ok),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   mps_board board_u (.pad_out_in(pad_out), .pad_oe_in(pad_oe), .pad_level_out(pad_in),
      .ext_in(ext), .button_in(button));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected {oe, value} of a pad from the current stimulus
   function automatic logic [1:0] exp_pin(input int p);
      logic [1:0] prt;
      prt = {port_oe[p], port_out[p]};
      case (p)
         P_MOSI: return en.md2_en ? 2'h0 : en.spi_en ? {1'b1, drv.spi_mosi} : prt;
         P_MISO: return (en.md2_en || en.spi_en) ? 2'h0 : prt;
         P_TX0:  return en.ser0_tx_busy ? {1'b1, drv.serial0_tx} : prt;
         P_TX1:  return en.ser1_tx_busy ? {1'b1, drv.serial1_tx} : prt;
         P_T2A:  return en.md1_en ? 2'h0 : en.tmr2_out_en ? {1'b1, drv.timer2_primary_pin} : prt;
         P_T2B:  return en.md1_en ? 2'h0 :
                        en.tmr2_out_en ? {1'b1, drv.timer2_secondary_pin} : prt;
         P_SDA:  return en.i2c_en ? {drv.sda_low, 1'b0} : prt;
         P_SCL:  return en.i2c_en ? {drv.scl_low, 1'b0} : prt;
         P_TMS, P_TCK, P_TDI: return en.jtag_en ? 2'h0 : prt;
         P_TBB:  return en.tmrb_b_out_en ? {1'b1, drv.timerb_pin_b} : prt;
         P_TBA:  return en.tmrb_a_out_en ? {1'b1, drv.timerb_pin_a} : prt;
         P_MD0P: return en.md0_en ? 2'h0 : prt;
         P_SSEL: return en.md0_en ? 2'h0 : en.spi_en ? {1'b1, drv.spi_ssel} : prt;
         P_CF1:  return en.pulse1_en ? {1'b1, drv.pulse_out_1} : prt;
         P_CF2:  return en.pulse2_en ? {1'b1, drv.pulse_out_2} : prt;
         P_TDO:  return en.jtag_en ? {drv.tdo_oe, drv.tdo} :
                        en.sqw_en ? {1'b1, drv.square_wave_out} : prt;
         P_SCLK: return ctrl_v[1] ? {1'b1, drv.sysclk_level} :
                        en.spi_en ? {1'b1, drv.spi_sclk} : prt;
         default: return prt;
      endcase
   endfunction

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_in);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_in); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Clock and watchdog
   // -----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial begin
      repeat (8000) @(posedge clk_in);
      n_fail++;
      end_of_test();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      mps_en_t     e;
      logic [21:0] po;
      logic [21:0] pe;
      logic [1:0]  xp;
      logic [1:0]  gp;
      r = 32'h0000000A;
      n_fail = 0;
      checked = 0;
      en = '0;
      drv = '0;
      port_out = '0;
      port_oe = '0;
      ext = '0;
      button = 1'b0;
      ctrl_v = 2'h0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      rst_in = 1'b1;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      axi_read(REG_CTRL);
      check({rs, rd}, {RESP_OKAY, 32'h0});
      axi_write(REG_OWNER, 32'hFFFFFFFF, 4'hF);
      check(34'(rs), 34'(RESP_OKAY));
      axi_read(REG_OWNER);
      check({rs, rd}, {RESP_OKAY, 32'h0});
      axi_write(8'h0C, 32'h00000003, 4'hF);
      check(34'(rs), 34'(RESP_SLVERR));
      axi_read(8'h0C);
      check({rs, rd}, {RESP_SLVERR, 32'h0});
      axi_write(REG_CTRL, 32'h00000003, 4'h0);
      axi_read(REG_CTRL);
      check({rs, rd}, {RESP_OKAY, 32'h0});
      for (int it = 0; it < 40; it++) begin
         r = lfsr(r);
         e = mps_en_t'(r[15:0]);
         if (e.md0_en || e.md2_en)
            e.spi_en = 1'b0;
         if (e.md1_en)
            e.tmr2_out_en = 1'b0;
         r = lfsr(r);
         po = r[21:0];
         r = lfsr(r);
         pe = r[21:0];
         if (e.md0_en)
            {pe[P_MD0P], pe[P_SSEL]} = 2'h0;
         if (e.md2_en)
            pe[P_MISO] = 1'b0;
         if (e.tmrb_a_out_en)
            pe[P_TBA] = 1'b0;
         ctrl_v = (it == 3) ? 2'h2 : (it == 4) ? 2'h1 : r[23:22];
         case (it)
            0: e = mps_en_t'(16'h3000);
            1: e = mps_en_t'(16'h0600);
            2: e = mps_en_t'(16'h4004);
            3: e = mps_en_t'(16'h1000);
            4: pe[P_RST] = 1'b0;
            5: begin
               e.ser0_tx_busy = 1'b0;
               po[P_TX0] = 1'b1;
               pe[P_TX0] = 1'b1;
            end
            default: ;
         endcase
         axi_write(REG_CTRL, {30'h0, ctrl_v}, 4'hF);
         en <= e;
         drv <= mps_drv_t'(r[31:15]);
         port_out <= po;
         port_oe <= pe;
         ext <= 22'(lfsr(r) >> 3);
         button <= (it == 4) ? 1'b1 : r[5];
         repeat (3) @(posedge clk_in);
         #1;
         for (int k = 0; k < NPIN; k++) begin
            xp = exp_pin(k);
            gp = {pad_oe[k], pad_oe[k] & pad_out[k]};
            check(34'(gp), 34'({xp[1], &xp}));
         end
         check(34'(rx0), 34'(en.ser0_rx_en ? pad_in[P_RX0] : 1'b1));
         check(34'(rx1), 34'(en.ser1_rx_en ? pad_in[P_RX1] : 1'b1));
         check(34'(dev_rst), 34'(!pad_in[P_RST] && !ctrl_v[0]));
         check(34'(spi_ok), 34'(en.spi_en && !ctrl_v[1] && !en.md0_en && !en.md2_en));
         check(34'(port_in[12:9]), 34'(en.jtag_en ? 4'h0 : pad_in[12:9]));
         check(34'(pin_in), 34'(pad_in));
         axi_read(REG_CTRL);
         check({rs, rd}, {RESP_OKAY, 30'h0, ctrl_v});
         axi_read(REG_OWNER);
         check(34'(rd[P_CF1]), 34'(en.pulse1_en));
         axi_read(REG_CONFLICT);
         check(34'(rd[P_TDO]), 34'(en.jtag_en && en.sqw_en));
      end
      end_of_test();
   end

endmodule
`default_nettype wire
